// file: src/nmcc_pkg.sv
package nmcc_pkg;

   // ****************************************
   // clock and timing
   // ****************************************
   localparam longint CLK_HZ    = 250_000_000;
   localparam longint COARSE_MS = 3000;  // 3 s
   localparam longint WAIT_MS   = 1500;  // 1.5 s
   localparam longint FINE_S    = 1500;  // 1500 s
   localparam longint TICK_HZ   = 200;
   localparam logic [39:0] COARSE_CYC = 40'(COARSE_MS * CLK_HZ / 1000);
   localparam logic [39:0] WAIT_CYC   = 40'(WAIT_MS * CLK_HZ / 1000);
   localparam logic [39:0] FINE_CYC   = 40'(FINE_S * CLK_HZ);
   localparam logic [20:0] TICK_CYC   = 21'(CLK_HZ / TICK_HZ);

   // ****************************************
   // ports, protocols, defaults
   // ****************************************
   localparam int NPORT  = 2;
   localparam int NPROTO = 9;
   localparam logic [3:0] PR_RAWIMU   = 4'h4;
   localparam logic [3:0] PR_RAWDATA  = 4'h6;
   localparam logic [3:0] PR_TEXTLITE = 4'h7;
   localparam logic [3:0] PR_POST     = 4'h8;
   localparam logic [3:0] PR_COUNT    = 4'h9;
   localparam logic [19:0] DEF_BAUD   = 20'h70800;  // 460800 bps
   localparam logic [9:0] DEF_PER_1HZ = 10'h0C8;
   localparam logic [9:0] DEF_PER_PST = 10'h001;
   localparam logic [9:0] MAX_TICKS   = 10'h3E8;
   localparam logic       MODE_GNSS   = 1'b0;
   localparam logic       MODE_INERT  = 1'b1;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] A_CMD    = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_BAUD0  = 8'h08;
   localparam logic [7:0] A_BAUD1  = 8'h0C;
   localparam logic [7:0] A_EN0    = 8'h10;
   localparam logic [7:0] A_EN1    = 8'h14;
   localparam logic [7:0] A_PSEL   = 8'h18;
   localparam logic [7:0] A_PDATA  = 8'h1C;
   localparam logic [7:0] A_IDENT  = 8'h20;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [3:0] {
      OP_NONE = 4'h0, OP_MODE_GNSS = 4'h1, OP_MODE_INERT = 4'h2,
      OP_SAVE = 4'h3, OP_SRESET = 4'h4, OP_QUERY = 4'h5, OP_BAUD = 4'h6,
      OP_LOG_ON = 4'h7, OP_LOG_OFF = 4'h8, OP_RAW_ON = 4'h9,
      OP_RAW_OFF = 4'hA, OP_UNLOG = 4'hB
   } nmcc_op_t;

   typedef enum logic [1:0] {
      ST_COARSE = 2'h0, ST_FINE = 2'h1, ST_INERTIAL = 2'h3, ST_INTEG = 2'h2
   } nmcc_state_t;

   typedef struct packed {
      logic [19:0] arg;
      logic [3:0]  proto;
      logic [1:0]  portn;
      logic        spare;
      logic        src;
      nmcc_op_t    op;
   } nmcc_cmd_t;

   typedef struct packed {
      logic                 mode;
      logic [1:0][19:0]     baud;
      logic [1:0][8:0]      en;
      logic [1:0][8:0][9:0] period;
   } nmcc_cfg_t;

   // settings after power-up
   function automatic nmcc_cfg_t def_cfg();
      nmcc_cfg_t c;
      c = '0;
      c.mode = MODE_GNSS;
      c.baud[0] = DEF_BAUD;
      c.baud[1] = DEF_BAUD;
      c.en[0][PR_TEXTLITE] = 1'b1;
      c.period[0][PR_TEXTLITE] = DEF_PER_1HZ;
      c.en[1][PR_POST] = 1'b1;
      c.period[1][PR_POST] = DEF_PER_PST;
      return c;
   endfunction

endpackage

// file: src/nmcc_console.sv
// Contract
// R1: two modes, GNSS-aided is power-up default
// R2: every command answers ok or error
// R3: save stores config, reloaded at restart
// R4: restart restores last saved config
// R5: commands select each default mode
// R6: coarse alignment lasts 3 s
// R7: aided flow needs valid GNSS to navigate
// R8: inertial coarse alignment 3 s awaiting GNSS
// R9: fine alignment on GNSS or after 1.5 s
// R10: fine alignment 1500 s then inertial navigation
// R11: host keeps module still while coarse
// R12: reset command soft resets, re-sends startup
// R13: two ports, each accepts all commands; the code answers query from the second port with error
// R14: host waits for startup prompt
// R15: query on first port reports configuration
// R16: baud command sets named port rate
// R17: period argument in 200 Hz ticks
// R18: enabling protocol adds to enabled set
// R19: off stops only that protocol
// R20: raw record on-new-sample, off disables
// R21: stop-all clears every protocol on port
// R22: host picks adequate baud rate
// R23: ports default to 460800 bps
// R24: bad command errors, config unchanged
// R25: scheduler emits every N base ticks
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module nmcc_console #(
   parameter logic [39:0] COARSE_CYC_P = nmcc_pkg::COARSE_CYC,
   parameter logic [39:0] WAIT_CYC_P   = nmcc_pkg::WAIT_CYC,
   parameter logic [39:0] FINE_CYC_P   = nmcc_pkg::FINE_CYC,
   parameter logic [20:0] TICK_CYC_P   = nmcc_pkg::TICK_CYC,
   parameter logic [31:0] IDENT_P      = 32'h00C0FFEE  // arbitrary value
) (
   // clock, reset, enable
   input  wire logic               clk_in,
   input  wire logic               reset_in,
   input  wire logic               ce_in,
   // ahb-lite slave
   input  wire logic               hsel_in,
   input  wire logic [31:0]        haddr_in,
   input  wire logic [1:0]         htrans_in,
   input  wire logic               hwrite_in,
   input  wire logic [2:0]         hsize_in,
   input  wire logic [31:0]        hwdata_in,
   input  wire logic               hready_in,
   output logic [31:0]             hrdata_out,
   output logic                    hreadyout_out,
   output logic                    hresp_out,
   // navigation side
   input  wire logic               gnss_valid_in,
   input  wire logic               sample_in,
   output logic [1:0]              nav_state_out,
   output logic                    active_mode_out,
   // serial port side
   output logic [1:0][19:0]        baud_out,
   output logic [1:0][8:0]         emit_out,
   // text replies
   output logic                    reply_ok_out,
   output logic                    reply_err_out,
   output logic                    query_out,
   output logic                    startup_info_out
);

   // ****************************************
   // ahb-lite slave
   // ****************************************
   logic                 wr_pend_reg;
   logic [7:0]           addr_reg;
   logic [31:0]          rdata_reg;
   logic [31:0]          rdata_next;
   logic                 acc;
   logic [4:0]           psel_reg;
   nmcc_pkg::nmcc_cfg_t  cfg_reg;
   nmcc_pkg::nmcc_cfg_t  saved_reg;
   nmcc_pkg::nmcc_state_t st_reg;
   nmcc_pkg::nmcc_state_t st_next;
   logic                 mode_reg;
   logic [39:0]          cnt_reg;
   logic                 ok_reg;
   logic                 err_reg;
   logic                 query_reg;
   logic [3:0]           last_op_reg;
   logic                 prompt_reg;
   logic                 boot_reg;
   logic                 startup_reg;

   // zero-wait slave, always okay
   assign hreadyout_out = 1'b1;
   assign hresp_out     = 1'b0;
   assign hrdata_out    = rdata_reg;
   assign acc = ce_in && hsel_in && hready_in && htrans_in[1];

   // read mux for the address phase
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (haddr_in[31:8] == 24'h00_0000) begin
         unique case (haddr_in[7:0])
            nmcc_pkg::A_STATUS: rdata_next = {20'h0_0000, last_op_reg, query_reg,
                                             saved_reg.mode, mode_reg, st_reg,
                                             prompt_reg, err_reg, ok_reg};
            nmcc_pkg::A_BAUD0:  rdata_next = {12'h000, cfg_reg.baud[0]};
            nmcc_pkg::A_BAUD1:  rdata_next = {12'h000, cfg_reg.baud[1]};
            nmcc_pkg::A_EN0:    rdata_next = {23'h00_0000, cfg_reg.en[0]};
            nmcc_pkg::A_EN1:    rdata_next = {23'h00_0000, cfg_reg.en[1]};
            nmcc_pkg::A_PSEL:   rdata_next = {27'h000_0000, psel_reg};
            nmcc_pkg::A_PDATA: begin
               if (psel_reg[3:0] < nmcc_pkg::PR_COUNT) begin
                  rdata_next = {22'h00_0000, cfg_reg.period[psel_reg[4]][psel_reg[3:0]]};
               end
            end
            nmcc_pkg::A_IDENT:  rdata_next = IDENT_P;
            default:            rdata_next = 32'h0000_0000;
         endcase
      end
   end

   // address phase capture, read data registered
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         wr_pend_reg <= 1'b0;
         addr_reg    <= 8'h00;
         rdata_reg   <= 32'h0000_0000;
      end else if (ce_in) begin
         wr_pend_reg <= acc && hwrite_in && (haddr_in[31:8] == 24'h00_0000);
         addr_reg    <= haddr_in[7:0];
         if (acc && !hwrite_in) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   // period readback selector
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         psel_reg <= 5'h00;
      end else if (ce_in && wr_pend_reg && addr_reg == nmcc_pkg::A_PSEL) begin
         psel_reg <= hwdata_in[4:0];
      end
   end

   // ****************************************
   // command decode
   // ****************************************
   nmcc_pkg::nmcc_cmd_t cmd;
   logic                go;
   logic                port_ok;
   logic                pi;
   logic                proto_ok;
   logic                onchg;
   logic                cmd_ok;
   logic                sreset;

   assign cmd      = nmcc_pkg::nmcc_cmd_t'(hwdata_in);
   assign go       = ce_in && wr_pend_reg && addr_reg == nmcc_pkg::A_CMD;  // R13
   assign port_ok  = cmd.portn == 2'h1 || cmd.portn == 2'h2;  // R16
   assign pi       = cmd.portn[1];
   assign proto_ok = cmd.proto < nmcc_pkg::PR_COUNT;
   assign onchg    = cmd.proto == nmcc_pkg::PR_RAWIMU || cmd.proto == nmcc_pkg::PR_RAWDATA;

   // argument checks per opcode
   always_comb begin
      unique case (cmd.op)
         nmcc_pkg::OP_MODE_GNSS,
         nmcc_pkg::OP_MODE_INERT,
         nmcc_pkg::OP_SAVE,
         nmcc_pkg::OP_SRESET:   cmd_ok = 1'b1;
         nmcc_pkg::OP_QUERY:    cmd_ok = !cmd.src;  // R15
         nmcc_pkg::OP_BAUD:     cmd_ok = port_ok && cmd.arg != 20'h0_0000;  // R16
         nmcc_pkg::OP_LOG_ON:   cmd_ok = port_ok && proto_ok && !onchg
                                         && cmd.arg != 20'h0_0000
                                         && cmd.arg <= {10'h000, nmcc_pkg::MAX_TICKS};  // R17
         nmcc_pkg::OP_LOG_OFF:  cmd_ok = port_ok && proto_ok;
         nmcc_pkg::OP_RAW_ON,
         nmcc_pkg::OP_RAW_OFF,
         nmcc_pkg::OP_UNLOG:    cmd_ok = port_ok;
         default:               cmd_ok = 1'b0;  // R24
      endcase
   end

   assign sreset = go && cmd_ok && cmd.op == nmcc_pkg::OP_SRESET;

   // ****************************************
   // configuration and saved copy
   // ****************************************
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         cfg_reg   <= nmcc_pkg::def_cfg();  // R1 R23
         saved_reg <= nmcc_pkg::def_cfg();
      end else if (go && cmd_ok) begin
         unique case (cmd.op)
            nmcc_pkg::OP_MODE_GNSS:  cfg_reg.mode <= nmcc_pkg::MODE_GNSS;  // R5
            nmcc_pkg::OP_MODE_INERT: cfg_reg.mode <= nmcc_pkg::MODE_INERT;  // R5
            nmcc_pkg::OP_SAVE:       saved_reg <= cfg_reg;  // R3
            nmcc_pkg::OP_SRESET:     cfg_reg <= saved_reg;  // R4
            nmcc_pkg::OP_BAUD:       cfg_reg.baud[pi] <= cmd.arg;  // R16
            nmcc_pkg::OP_LOG_ON: begin
               cfg_reg.en[pi][cmd.proto] <= 1'b1;  // R18
               cfg_reg.period[pi][cmd.proto] <= cmd.arg[9:0];  // R17
            end
            nmcc_pkg::OP_LOG_OFF:    cfg_reg.en[pi][cmd.proto] <= 1'b0;  // R19
            nmcc_pkg::OP_RAW_ON:     cfg_reg.en[pi][nmcc_pkg::PR_RAWDATA] <= 1'b1;  // R20
            nmcc_pkg::OP_RAW_OFF:    cfg_reg.en[pi][nmcc_pkg::PR_RAWDATA] <= 1'b0;  // R20
            nmcc_pkg::OP_UNLOG:      cfg_reg.en[pi] <= 9'h000;  // R21
            default:                 cfg_reg <= cfg_reg;
         endcase
      end
   end

   assign baud_out = cfg_reg.baud;

   // ****************************************
   // replies and startup prompt
   // ****************************************
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         ok_reg      <= 1'b0;
         err_reg     <= 1'b0;
         query_reg   <= 1'b0;
         last_op_reg <= 4'h0;
      end else if (ce_in) begin
         ok_reg    <= go && cmd_ok;  // R2
         err_reg   <= go && !cmd_ok;  // R2 R24
         query_reg <= go && cmd_ok && cmd.op == nmcc_pkg::OP_QUERY;  // R15
         if (go) begin
            last_op_reg <= cmd.op;
         end
      end
   end

   // startup text after power-up and after soft reset
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         boot_reg    <= 1'b1;
         prompt_reg  <= 1'b0;
         startup_reg <= 1'b0;
      end else if (ce_in) begin
         boot_reg    <= 1'b0;
         startup_reg <= boot_reg || sreset;  // R12
         prompt_reg  <= 1'b1;
      end
   end

   assign reply_ok_out     = ok_reg;
   assign reply_err_out    = err_reg;
   assign query_out        = query_reg;
   assign startup_info_out = startup_reg;

   // ****************************************
   // alignment sequencer
   // ****************************************
   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         nmcc_pkg::ST_COARSE: begin
            if (cnt_reg >= COARSE_CYC_P - 40'h1) begin  // R6 R8
               if (gnss_valid_in) begin
                  st_next = (mode_reg == nmcc_pkg::MODE_GNSS) ?
                            nmcc_pkg::ST_INTEG : nmcc_pkg::ST_FINE;  // R7 R9
               end else if (mode_reg == nmcc_pkg::MODE_INERT &&
                            cnt_reg >= COARSE_CYC_P + WAIT_CYC_P - 40'h1) begin
                  st_next = nmcc_pkg::ST_FINE;  // R9
               end
            end
         end
         nmcc_pkg::ST_FINE: begin
            if (cnt_reg >= FINE_CYC_P - 40'h1) begin
               st_next = nmcc_pkg::ST_INERTIAL;  // R10
            end
         end
         nmcc_pkg::ST_INERTIAL,
         nmcc_pkg::ST_INTEG: st_next = st_reg;
      endcase
   end

   // state, time in state, mode of the running flow
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         st_reg   <= nmcc_pkg::ST_COARSE;
         cnt_reg  <= 40'h00_0000_0000;
         mode_reg <= nmcc_pkg::MODE_GNSS;  // R1
      end else if (ce_in) begin
         if (sreset) begin
            st_reg   <= nmcc_pkg::ST_COARSE;  // R12
            cnt_reg  <= 40'h00_0000_0000;
            mode_reg <= saved_reg.mode;  // R4
         end else begin
            st_reg <= st_next;
            if (st_next != st_reg) begin
               cnt_reg <= 40'h00_0000_0000;
            end else if (cnt_reg != 40'hFF_FFFF_FFFF) begin
               cnt_reg <= cnt_reg + 40'h1;
            end
         end
      end
   end

   assign nav_state_out   = st_reg;
   assign active_mode_out = mode_reg;

   // ****************************************
   // output scheduler
   // ****************************************
   logic [20:0]          tick_cnt_reg;
   logic                 tick;
   logic [1:0][8:0][9:0] per_cnt_reg;
   logic [1:0][8:0]      emit_reg;

   assign tick = tick_cnt_reg >= TICK_CYC_P - 21'h1;

   // 200 hz base tick
   always_ff @(posedge clk_in) begin
      if (reset_in || (ce_in && sreset)) begin
         tick_cnt_reg <= 21'h00_0000;
      end else if (ce_in) begin
         tick_cnt_reg <= tick ? 21'h00_0000 : tick_cnt_reg + 21'h1;  // R25
      end
   end

   // per port and protocol emission
   always_ff @(posedge clk_in) begin
      if (reset_in || (ce_in && sreset)) begin
         per_cnt_reg <= '0;
         emit_reg    <= '0;
      end else if (ce_in) begin
         for (int p = 0; p < nmcc_pkg::NPORT; p++) begin
            for (int k = 0; k < nmcc_pkg::NPROTO; k++) begin
               emit_reg[p][k] <= 1'b0;
               if (!cfg_reg.en[p][k]) begin
                  per_cnt_reg[p][k] <= 10'h000;
               end else if (4'(k) == nmcc_pkg::PR_RAWIMU ||
                            4'(k) == nmcc_pkg::PR_RAWDATA) begin
                  emit_reg[p][k] <= sample_in;  // R20
               end else if (tick) begin
                  if (per_cnt_reg[p][k] >= cfg_reg.period[p][k] - 10'h1) begin
                     emit_reg[p][k]    <= 1'b1;  // R25
                     per_cnt_reg[p][k] <= 10'h000;
                  end else begin
                     per_cnt_reg[p][k] <= per_cnt_reg[p][k] + 10'h1;
                  end
               end
            end
         end
      end
   end

   assign emit_out = emit_reg;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   AST_POWERUP_MODE: assert property ($past(reset_in) |-> !mode_reg && !cfg_reg.mode) // R1
      else $error("power-up mode not gnss-aided");
   AST_ONE_REPLY: assert property (go |=> reply_ok_out != reply_err_out) // R2
      else $error("command without single reply");
   AST_SAVE: assert property (go && cmd_ok && cmd.op == nmcc_pkg::OP_SAVE
                              |=> saved_reg == $past(cfg_reg)) // R3
      else $error("save did not store config");
   AST_RESTORE: assert property (sreset |=> cfg_reg == $past(saved_reg)
                                 && mode_reg == $past(saved_reg.mode)) // R4
      else $error("soft reset did not restore saved config");
   AST_MODE_CMD: assert property (go && cmd.op == nmcc_pkg::OP_MODE_INERT
                                  |=> cfg_reg.mode == nmcc_pkg::MODE_INERT) // R5
      else $error("mode command ignored");
   AST_COARSE_LEN: assert property ($past(st_reg) == nmcc_pkg::ST_COARSE
                                    && st_reg != nmcc_pkg::ST_COARSE
                                    |-> $past(cnt_reg) >= COARSE_CYC_P - 40'h1) // R6
      else $error("coarse alignment too short");
   AST_AIDED_VALID: assert property ($past(st_reg) == nmcc_pkg::ST_COARSE
                                     && st_reg == nmcc_pkg::ST_INTEG
                                     |-> $past(gnss_valid_in) && !mode_reg) // R7
      else $error("integrated navigation without valid gnss");
   AST_FINE_WAIT: assert property ($past(st_reg) == nmcc_pkg::ST_COARSE
                                   && st_reg == nmcc_pkg::ST_FINE && !$past(gnss_valid_in)
                                   |-> $past(cnt_reg) >= COARSE_CYC_P + WAIT_CYC_P - 40'h1) // R9
      else $error("fine alignment entered early");
   AST_FINE_LEN: assert property ($past(st_reg) == nmcc_pkg::ST_FINE
                                  && st_reg == nmcc_pkg::ST_INERTIAL
                                  |-> $past(cnt_reg) >= FINE_CYC_P - 40'h1) // R10
      else $error("fine alignment too short");
   AST_STARTUP: assert property (sreset |=> startup_info_out
                                 && st_reg == nmcc_pkg::ST_COARSE) // R12
      else $error("soft reset without startup text");
   AST_QUERY: assert property (go && cmd.op == nmcc_pkg::OP_QUERY
                               |=> query_out == !$past(cmd.src)) // R15
      else $error("query answered on wrong port");
   AST_UNLOG: assert property (go && cmd_ok && cmd.op == nmcc_pkg::OP_UNLOG
                               |=> cfg_reg.en[$past(pi)] == 9'h000) // R21
      else $error("stop-all left a protocol on");
   AST_BAD_KEEPS: assert property (go && !cmd_ok |=> cfg_reg == $past(cfg_reg)) // R24
      else $error("rejected command changed config");

   COV_INTEG: cover property (st_reg == nmcc_pkg::ST_INTEG);
   COV_INERTIAL: cover property (st_reg == nmcc_pkg::ST_INERTIAL);
   COV_EMIT: cover property (emit_reg != '0);
   COV_ERROR: cover property (reply_err_out);

endmodule

`default_nettype wire

// file: verif/nmcc_nav_model.sv
`timescale 1ns/100ps
`default_nettype none

module nmcc_nav_model (
   // clock
   input  wire logic clk_in,
   // bench control
   input  wire logic fix_in,
   input  wire logic raw_in,
   // to console
   output var logic  gnss_valid_out = 1'b0,
   output var logic  sample_out = 1'b0
);
   // fix level follows one cycle late, raw request becomes a one-cycle pulse
   always_ff @(posedge clk_in) begin
      gnss_valid_out <= fix_in;
      sample_out     <= raw_in & ~sample_out;
   end
endmodule

`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
   logic                 clk_in = 1'b0;
   logic                 reset_in = 1'b1;
   logic                 fix = 1'b0;
   logic                 raw = 1'b0;
   logic                 ce = 1'b1;
   logic [31:0]          haddr = 32'h0;
   logic [31:0]          hwdata = 32'h0;
   logic [1:0]           htrans = 2'h0;
   logic                 hwrite = 1'b0;
   logic [2:0]           hsize = 3'h2;
   wire logic [31:0]     hrdata;
   wire logic            hready, hresp, gv, smp, rok, rerr, qry, sup, amode;
   wire logic [1:0]      nst;
   wire logic [1:0][19:0] baud;
   wire logic [1:0][8:0] emit;
   int                   n_mismatch = 0;
   int                   cmp_count = 0;
   int                   n;
   logic [31:0]          rv;

   // ****************************************
   // design and navigation side
   // ****************************************
   nmcc_console #(.COARSE_CYC_P(40'h28), .WAIT_CYC_P(40'h14), .FINE_CYC_P(40'h3C),
      .TICK_CYC_P(21'h4)) nmcc_console_inst (.clk_in(clk_in), .reset_in(reset_in),
      .ce_in(ce), .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
      .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
      .gnss_valid_in(gv), .sample_in(smp), .nav_state_out(nst),
      .active_mode_out(amode), .baud_out(baud), .emit_out(emit), .reply_ok_out(rok),
      .reply_err_out(rerr), .query_out(qry), .startup_info_out(sup));
   nmcc_nav_model nmcc_nav_model_inst (.clk_in(clk_in), .fix_in(fix), .raw_in(raw),
      .gnss_valid_out(gv), .sample_out(smp));

   // ****************************************
   // helpers
   // ****************************************
   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rng(string nm, int lo, int hi, int g);
      cmp_count++;
      if (g < lo || g > hi) begin
         n_mismatch++;
         $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask

   // wait for hready under a bound
   task automatic hwait();
      int k;
      k = 0;
      do begin
         @(posedge clk_in);
         k++;
      end while (hready !== 1'b1 && k < 50);
      if (k >= 50) begin
         chk("hready", 32'h1, 32'(hready));
         conclude();
      end
   endtask

   // one single word transfer, address phase then data phase
   task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
      @(posedge clk_in);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      hwait();
      htrans <= 2'h0;
      hwdata <= d;
      hwait();
      r = hrdata;
      #1;
   endtask

   function automatic logic [31:0] cw(logic [3:0] op, logic [1:0] pt, logic [3:0] pr,
      logic [19:0] arg, logic src = 1'b0);
      return {arg, pr, pt, 1'b0, src, op};
   endfunction

   // command write and its reply pulse
   task automatic cmd(logic [31:0] w, logic ok);
      xfer(1'b1, nmcc_pkg::A_CMD, w, rv);
      chk("reply_ok", 32'(ok), 32'(rok));
      chk("reply_err", 32'(!ok), 32'(rerr));
   endtask

   task automatic wst(logic [1:0] s);
      n = 0;
      while (nst !== s && n < 500) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      if (n >= 500) begin
         chk("nav_wait", 32'(s), 32'(nst));
         conclude();
      end
   endtask

   // wait for the next pulse on one emit line
   task automatic wem(int p, int k);
      n = 0;
      do begin
         @(posedge clk_in);
         #1;
         n++;
      end while (emit[p][k] !== 1'b1 && n < 100);
      if (n >= 100) begin
         chk("emit_wait", 32'h1, 32'(emit[p][k]));
         conclude();
      end
   endtask

   // raw sample request, look for the record pulse on the second port
   task automatic rawchk(logic e);
      logic seen;
      seen = 1'b0;
      @(posedge clk_in);
      raw <= 1'b1;
      @(posedge clk_in);
      raw <= 1'b0;
      repeat (4) begin
         @(posedge clk_in);
         #1;
         seen = seen | emit[1][nmcc_pkg::PR_RAWDATA];
      end
      chk("raw_emit", 32'(e), 32'(seen));
   endtask

   // ****************************************
   // clock and main sequence
   // ****************************************
   initial begin
      forever #2 clk_in = ~clk_in;
   end

   initial begin
      repeat (20) @(posedge clk_in);
      reset_in <= 1'b0;
      @(posedge clk_in);
      #1;
      chk("startup", 32'h1, 32'(sup));
      chk("baud0", 32'(nmcc_pkg::DEF_BAUD), 32'(baud[0]));
      chk("baud1", 32'(nmcc_pkg::DEF_BAUD), 32'(baud[1]));
      chk("mode", 32'(nmcc_pkg::MODE_GNSS), 32'(amode));
      cmd(cw(4'h6, 2'h1, 4'h0, 20'h1C200), 1'b1);
      chk("baud0", 32'h1C200, 32'(baud[0]));
      cmd(cw(4'h6, 2'h3, 4'h0, 20'h2580), 1'b0);
      cmd(cw(4'h6, 2'h2, 4'h0, 20'h0), 1'b0);
      chk("baud1", 32'(nmcc_pkg::DEF_BAUD), 32'(baud[1]));
      cmd(cw(4'h7, 2'h2, 4'h0, 20'h2), 1'b1);
      cmd(cw(4'h7, 2'h2, 4'h1, 20'h2), 1'b1);
      xfer(1'b0, nmcc_pkg::A_EN1, 32'h0, rv);
      chk("en1", 32'h103, rv);
      xfer(1'b1, nmcc_pkg::A_PSEL, 32'h10, rv);
      xfer(1'b0, nmcc_pkg::A_PDATA, 32'h0, rv);
      chk("period1_0", 32'h2, rv);
      chk("hresp", 32'h0, 32'(hresp));
      wem(1, 0);
      wem(1, 0);
      chk("period", 32'h8, 32'(n));
      for (int i = 0; i < 5; i++) begin
         cmd(cw(i == 3 ? 4'hC : 4'h7, 2'h2, i == 1 ? 4'h9 : (i == 2 ? 4'h4 : 4'h0),
            i == 0 ? 20'h0 : (i == 4 ? 20'h3E9 : 20'h2)), 1'b0);
      end
      cmd(cw(4'h8, 2'h2, 4'h0, 20'h0), 1'b1);
      xfer(1'b0, nmcc_pkg::A_EN1, 32'h0, rv);
      chk("en1", 32'h102, rv);
      cmd(cw(4'h9, 2'h2, 4'h4, 20'h0), 1'b1);
      rawchk(1'b1);
      cmd(cw(4'hA, 2'h2, 4'h4, 20'h0), 1'b1);
      rawchk(1'b0);
      cmd(cw(4'hB, 2'h2, 4'h0, 20'h0), 1'b1);
      xfer(1'b0, nmcc_pkg::A_EN1, 32'h0, rv);
      chk("en1", 32'h0, rv);
      xfer(1'b0, nmcc_pkg::A_EN0, 32'h0, rv);
      chk("en0", 32'h80, rv);
      cmd(cw(4'h5, 2'h1, 4'h0, 20'h0, 1'b1), 1'b0);
      cmd(cw(4'h5, 2'h1, 4'h0, 20'h0), 1'b1);
      chk("query", 32'h1, 32'(qry));
      cmd(cw(4'h2, 2'h1, 4'h0, 20'h0), 1'b1);
      cmd(cw(4'h3, 2'h1, 4'h0, 20'h0), 1'b1);
      cmd(cw(4'h6, 2'h2, 4'h0, 20'h2580), 1'b1);
      cmd(cw(4'h4, 2'h1, 4'h0, 20'h0), 1'b1);
      chk("startup", 32'h1, 32'(sup));
      chk("mode", 32'(nmcc_pkg::MODE_INERT), 32'(amode));
      chk("baud1", 32'(nmcc_pkg::DEF_BAUD), 32'(baud[1]));
      chk("baud0", 32'h1C200, 32'(baud[0]));
      wst(2'h1);
      rng("to_fine", 57, 63, n);
      // freeze ten cycles, the fine count must not move
      ce <= 1'b0;
      repeat (10) @(posedge clk_in);
      ce <= 1'b1;
      wst(2'h3);
      rng("to_inertial", 57, 63, n);
      cmd(cw(4'h1, 2'h1, 4'h0, 20'h0), 1'b1);
      cmd(cw(4'h3, 2'h1, 4'h0, 20'h0), 1'b1);
      cmd(cw(4'h4, 2'h1, 4'h0, 20'h0), 1'b1);
      repeat (80) @(posedge clk_in);
      #1;
      chk("nav", 32'h0, 32'(nst));
      fix <= 1'b1;
      wst(2'h2);
      rng("to_integ", 1, 4, n);
      cmd(cw(4'h4, 2'h1, 4'h0, 20'h0), 1'b1);
      wst(2'h2);
      rng("coarse_len", 37, 43, n);
      conclude();
   end
endmodule

`default_nettype wire
